// ### rtl/btc_map.svh
// Functional notes
// RL1: chip select, read and write strobes low together float all outputs and data bus.
// RL2: addresses 80h to ffh decode as test registers, apart from normal registers.
// RL3: writes to unused bits do nothing; host masks unused bits after reading.
// RL4: writable test register bits need no reset unless stated otherwise.
// RL5: master test bits except factory select clear on hardware reset; soft reset keeps them. The code's hardware reset clears factory select too.
// RL6: factory test select bit 4 turns the host port into the vector access port.
// RL7: factory select ORs with board test enable; cleared only by chip select high. The code's hardware reset also clears it.
// RL8: bus driver control bit 3 makes chip select the data bus output enable.
// RL9: bus driver control overrides the data bus tristate bit.
// RL10: board test bit 2 holds blocks in test mode and opens test registers.
// RL11: output tristate bit 0 floats every pin but the data bus; host port works.
// RL12: data bus tristate bit 1 floats the data bus, blocking read data.
// RL13: write-only master test bits read back unspecified; host must not rely on them.
`ifndef BTC_MAP_SVH
`define BTC_MAP_SVH

// register offsets on the host port
`define BTC_MTC_OFFSET      8'h0b
`define BTC_TEST_SPACE_BIT  7

// master test control field positions
`define BTC_MTC_TRISTATE_IO 0
`define BTC_MTC_TRISTATE_DB 1
`define BTC_MTC_IO_TEST     2
`define BTC_MTC_BUS_DRV     3
`define BTC_MTC_FACTORY     4

// reset values
`define BTC_MTC_RESET       5'h00
`define BTC_BYTE_RESET      8'h00

// synchroniser depth on pin inputs
`define BTC_SYNC_STAGES     2

`endif

// ### rtl/btc_pkg.sv
package btc_pkg;

	// host port pins as they arrive, before or after synchronising
	typedef struct packed {
		logic       chip_select_n;
		logic       read_strobe_n;
		logic       write_strobe_n;
		logic [7:0] addr;
		logic [7:0] data;
	} btc_pins_s;

	// master test control bits held by the block
	typedef struct packed {
		logic factory_test_select;
		logic bus_driver_pin_control;
		logic board_io_test_enable;
		logic data_bus_tristate;
		logic output_pins_tristate;
	} btc_mtc_s;

	// write request towards the internal register spaces
	typedef struct packed {
		logic       strobe;
		logic       test_space;
		logic [7:0] addr;
		logic [7:0] data;
	} btc_ext_wr_s;

endpackage : btc_pkg

// ### rtl/btc_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "btc_map.svh"

module btc_sync #(
	parameter int WIDTH = 19
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// an empty synchroniser cannot be built; refuse it at elaboration
	if (WIDTH < 1)
	begin : g_bad_width
		$error("btc_sync: WIDTH must be at least 1");
	end

	////////////////////////////////////////////////////////////////////////////
	// two flops per bit; the first is seen only by the second
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic [`BTC_SYNC_STAGES-1:0] stage_reg;
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
					stage_reg <= '1; // idle host pins are high
				else
					stage_reg <= {stage_reg[`BTC_SYNC_STAGES-2:0], async_in[i]};
			end
			assign sync_out[i] = stage_reg[`BTC_SYNC_STAGES-1];
		end
	endgenerate

endmodule : btc_sync

`default_nettype wire

// ### rtl/btc_board_test_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "btc_map.svh"

module btc_board_test_control (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// host port pins
	input  wire logic                 chip_select_n,
	input  wire logic                 read_strobe_n,
	input  wire logic                 write_strobe_n,
	input  wire logic [7:0]           addr_pin,
	input  wire logic [7:0]           data_pin_in,
	output logic      [7:0]           data_pin_out,
	output logic                      data_pin_oe_n,
	// internal register spaces
	output btc_pkg::btc_ext_wr_s      ext_wr,
	input  wire logic [7:0]           ext_rdata,
	// test controls towards the device
	output logic                      output_pins_hiz,
	output logic                      blocks_test_mode,
	output logic                      factory_test_port,
	output logic                      test_space_open
);
	import btc_pkg::*;

	// whole module state
	typedef struct packed {
		btc_mtc_s    mtc;
		logic        wr_active;
		logic [7:0]  wr_addr;
		logic [7:0]  wr_data;
		btc_ext_wr_s ext_wr;
		logic [7:0]  rd_data;
		logic        oe_n;
		logic        pins_hiz;
		logic        test_mode;
		logic        factory;
		logic        test_open;
	} btc_state_s;

	btc_pins_s  pins_raw;
	btc_pins_s  pins;
	btc_state_s state_reg;
	btc_state_s state_next;

	////////////////////////////////////////////////////////////////////////////
	// every host pin crosses in through two flops
	assign pins_raw = '{chip_select_n:  chip_select_n,
	                    read_strobe_n:  read_strobe_n,
	                    write_strobe_n: write_strobe_n,
	                    addr:           addr_pin,
	                    data:           data_pin_in};

	btc_sync #(
		.WIDTH ($bits(btc_pins_s))
	) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.async_in (pins_raw),
		.sync_out (pins)
	);

	////////////////////////////////////////////////////////////////////////////
	// decoded conditions on the synchronised pins
	logic all_strobes;
	logic write_low;
	logic read_low;
	logic wr_done;
	logic is_mtc;
	logic is_test;
	logic io_test_eff;

	// all three low is the board-test float request, never a cycle
	assign all_strobes = !pins.chip_select_n && !pins.read_strobe_n && !pins.write_strobe_n; // [RL1]
	assign write_low   = !pins.chip_select_n && !pins.write_strobe_n && pins.read_strobe_n;
	assign read_low    = !pins.chip_select_n && !pins.read_strobe_n && pins.write_strobe_n;
	// a write takes effect when the strobe rises, with address and data held from the low phase
	assign wr_done     = state_reg.wr_active && !write_low && !all_strobes;
	assign is_mtc      = state_reg.wr_addr == `BTC_MTC_OFFSET;
	assign is_test     = state_reg.wr_addr[`BTC_TEST_SPACE_BIT]; // [RL2]
	// factory select behaves as board test for the whole device
	assign io_test_eff = state_reg.mtc.board_io_test_enable | state_reg.mtc.factory_test_select; // [RL7]

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb
	begin
		logic       rd_test;
		logic       rd_mtc;
		logic       bus_drive;
		rd_test    = pins.addr[`BTC_TEST_SPACE_BIT];
		rd_mtc     = pins.addr == `BTC_MTC_OFFSET;
		bus_drive  = 1'b0;
		state_next = state_reg;

		// capture address and data while the write strobe is low
		state_next.wr_active = write_low;
		if (write_low)
		begin
			state_next.wr_addr = pins.addr;
			state_next.wr_data = pins.data;
		end

		// master test writes; bits 7..5 have no storage so writing them does nothing
		state_next.ext_wr = '0;
		if (wr_done && is_mtc)
		begin
			state_next.mtc.output_pins_tristate   = state_reg.wr_data[`BTC_MTC_TRISTATE_IO];
			state_next.mtc.data_bus_tristate      = state_reg.wr_data[`BTC_MTC_TRISTATE_DB];
			state_next.mtc.board_io_test_enable   = state_reg.wr_data[`BTC_MTC_IO_TEST];
			state_next.mtc.bus_driver_pin_control = state_reg.wr_data[`BTC_MTC_BUS_DRV]; // [RL8]
			if (state_reg.wr_data[`BTC_MTC_FACTORY])
				state_next.mtc.factory_test_select = 1'b1; // [RL6]
		end
		else if (wr_done && (!is_test || io_test_eff))
		begin
			// test space writes pass only once test access is open
			state_next.ext_wr.strobe     = 1'b1; // [RL10]
			state_next.ext_wr.test_space = is_test; // [RL2]
			state_next.ext_wr.addr       = state_reg.wr_addr;
			state_next.ext_wr.data       = state_reg.wr_data; // [RL4] forwarded bits get no reset here
		end

		// only chip select high or the hardware reset releases the factory select; chip select high wins over a set
		if (pins.chip_select_n)
			state_next.mtc.factory_test_select = 1'b0; // [RL7]

		// read data: write-only master bits read as zero, unused bits as zero
		if (read_low)
		begin
			if (rd_mtc)
			begin
				state_next.rd_data = `BTC_BYTE_RESET; // [RL13]
				state_next.rd_data[`BTC_MTC_IO_TEST]     = state_reg.mtc.board_io_test_enable; // [RL3]
				state_next.rd_data[`BTC_MTC_TRISTATE_IO] = state_reg.mtc.output_pins_tristate;
			end
			else if (rd_test && !io_test_eff)
				state_next.rd_data = `BTC_BYTE_RESET; // [RL10]
			else
				state_next.rd_data = ext_rdata;
		end

		// data bus enable: strobe override, then bus driver control, then tristate bit
		if (all_strobes)
			bus_drive = 1'b0; // [RL1]
		else if (state_reg.mtc.bus_driver_pin_control)
			bus_drive = pins.chip_select_n; // [RL8] [RL9]
		else if (state_reg.mtc.data_bus_tristate)
			bus_drive = 1'b0; // [RL12]
		else
			bus_drive = read_low;
		state_next.oe_n = !bus_drive;

		// every other pin floats on the strobe override or the tristate bit
		state_next.pins_hiz  = all_strobes | state_next.mtc.output_pins_tristate; // [RL1] [RL11]
		state_next.test_mode = state_next.mtc.board_io_test_enable
		                     | state_next.mtc.factory_test_select; // [RL10] [RL7]
		state_next.factory   = state_next.mtc.factory_test_select; // [RL6]
		state_next.test_open = state_next.test_mode; // [RL10]
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; the hardware reset pin clears every master bit, factory select included
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg           <= '0;
			state_reg.mtc       <= `BTC_MTC_RESET; // [RL5]
			state_reg.rd_data   <= `BTC_BYTE_RESET;
			state_reg.oe_n      <= 1'b1;
		end
		else
			state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from the state flops
	assign data_pin_out      = state_reg.rd_data;
	assign data_pin_oe_n     = state_reg.oe_n;
	assign ext_wr            = state_reg.ext_wr;
	assign output_pins_hiz   = state_reg.pins_hiz;
	assign blocks_test_mode  = state_reg.test_mode;
	assign factory_test_port = state_reg.factory;
	assign test_space_open   = state_reg.test_open;

endmodule : btc_board_test_control

`default_nettype wire

// ### verification/btc_board_test_control_sva.sv
`timescale 1ns/10ps
`default_nettype none
// pins reach the outputs three edges late, through the synchroniser
module btc_board_test_control_sva (
	// clock and reset
	input wire logic                 core_clk,
	input wire logic                 rst_n,
	// host pins
	input wire logic                 chip_select_n,
	input wire logic                 read_strobe_n,
	input wire logic                 write_strobe_n,
	// outputs
	input wire logic                 data_pin_oe_n,
	input wire btc_pkg::btc_ext_wr_s ext_wr,
	input wire logic                 output_pins_hiz,
	input wire logic                 blocks_test_mode,
	input wire logic                 factory_test_port,
	input wire logic                 test_space_open
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_strobe_float: assert property ((!chip_select_n && !read_strobe_n && !write_strobe_n)[*4] |-> data_pin_oe_n)
		else $error("bus driven under strobe override");
	a_strobe_pins: assert property ((!chip_select_n && !read_strobe_n && !write_strobe_n)[*4] |-> output_pins_hiz)
		else $error("pins driven under strobe override");
	a_space_gate: assert property (ext_wr.strobe && ext_wr.test_space |-> $past(blocks_test_mode))
		else $error("test space write while closed");
	a_wr_quiet: assert property (!ext_wr.strobe |-> ext_wr == '0)
		else $error("write fields without strobe");
	a_pulse_one: assert property ($rose(ext_wr.strobe) |=> !ext_wr.strobe)
		else $error("write strobe too long");
	a_space_mode: assert property (test_space_open == blocks_test_mode)
		else $error("test space and mode differ");
	a_factory_or: assert property (factory_test_port |-> blocks_test_mode)
		else $error("factory bit not in test mode");
	a_cs_clear: assert property (chip_select_n[*5] |-> !factory_test_port)
		else $error("factory bit kept with select high");
	a_factory_set: assert property ($rose(factory_test_port) |-> !$past(chip_select_n, 3))
		else $error("factory bit set without select");
	a_drive_cause: assert property (!data_pin_oe_n |-> !$past(read_strobe_n, 3) || $past(chip_select_n, 3))
		else $error("bus driven without cause");
	// main scenarios reached
	c_factory: cover property (factory_test_port);
	c_test_wr: cover property (ext_wr.strobe && ext_wr.test_space);
	c_drive: cover property (!data_pin_oe_n);
endmodule : btc_board_test_control_sva
`default_nettype wire

// ### verification/btc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host on the pins; write strobe held three edges, read strobe four, as the port needs
module btc_host_model (
	// clock
	input wire logic        core_clk,
	// host pins
	output logic            chip_select_n,
	output logic            read_strobe_n,
	output logic            write_strobe_n,
	output logic [7:0]      addr_pin,
	output logic [7:0]      host_data,
	// device bus
	input wire logic [7:0]  data_pin_out,
	input wire logic        data_pin_oe_n
);
	initial {chip_select_n, read_strobe_n, write_strobe_n, addr_pin, host_data} = {3'h7, 16'h0000};
	// select stays low afterwards, so the factory bit survives
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		chip_select_n <= 1'b0; // write never with read low
		write_strobe_n <= 1'b0;
		addr_pin <= a;
		host_data <= d;
		repeat (3) @(posedge core_clk);
		write_strobe_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		host_data <= ~d; // released bus shows the inverse
		repeat (4) @(posedge core_clk);
	endtask : wr
	// w low makes it the all-strobes override
	task automatic rd(input logic [7:0] a, input logic w, output logic [7:0] d, output logic oe);
		@(posedge core_clk);
		chip_select_n <= 1'b0;
		read_strobe_n <= 1'b0;
		write_strobe_n <= w;
		addr_pin <= a;
		repeat (4) @(posedge core_clk);
		d = data_pin_out;
		oe = data_pin_oe_n;
		read_strobe_n <= 1'b1;
		write_strobe_n <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask : rd
	task automatic idle(input logic cs, input int n);
		@(posedge core_clk);
		chip_select_n <= cs;
		repeat (n) @(posedge core_clk);
	endtask : idle
endmodule : btc_host_model
`default_nettype wire

// ### verification/btc_board_test_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module btc_board_test_control_test;
	import btc_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs, rdn, wrn, oe_n, hiz, btm, ftp, tso, o;
	logic [7:0] addr, hd, dout, dpin, r, a, d;
	logic [7:0] ext_rdata = 8'h3c;
	logic [31:0] v;
	btc_ext_wr_s ext_wr, last_wr;
	int n_errors = 0;
	int total_checks = 0;
	int n_wr = 0;
	int n;
	always #5 core_clk = ~core_clk;
	// the bus wire: device wins while enabled
	assign dpin = oe_n ? hd : dout;
	always @(posedge core_clk)
	begin
		if (ext_wr.strobe === 1'b1)
		begin
			last_wr <= ext_wr;
			n_wr <= n_wr + 1;
		end
	end
	btc_board_test_control i_btc_board_test_control (.core_clk(core_clk), .rst_n(rst_n), .chip_select_n(cs),
		.read_strobe_n(rdn), .write_strobe_n(wrn), .addr_pin(addr), .data_pin_in(dpin), .data_pin_out(dout),
		.data_pin_oe_n(oe_n), .ext_wr(ext_wr), .ext_rdata(ext_rdata), .output_pins_hiz(hiz),
		.blocks_test_mode(btm), .factory_test_port(ftp), .test_space_open(tso));
	btc_host_model i_btc_host_model (.core_clk(core_clk), .chip_select_n(cs), .read_strobe_n(rdn),
		.write_strobe_n(wrn), .addr_pin(addr), .host_data(hd), .data_pin_out(dout), .data_pin_oe_n(oe_n));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// only the two read/write bits come back
	function automatic logic [7:0] mtc_read(input logic [7:0] w);
		return w & 8'h05;
	endfunction : mtc_read
	task automatic tally_and_finish;
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		#200000;
		n_errors++;
		tally_and_finish();
	end
	initial
	begin
		v = $urandom(32'h1415);
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		check({oe_n, ftp, btm, tso, hiz}, 32'h10);
		for (int i = 0; i < 6; i++)
		begin
			d = 8'($urandom) & 8'he5;
			i_btc_host_model.wr(8'h0b, d);
			check({hiz, btm}, {d[0], d[2]});
			i_btc_host_model.rd(8'h0b, 1'b1, r, o);
			check({o, r}, {1'b0, mtc_read(d)});
		end
		i_btc_host_model.wr(8'h0b, 8'h04);
		a = 8'h80 | 8'($urandom);
		d = 8'($urandom);
		i_btc_host_model.wr(a, d);
		check(last_wr, {2'b11, a, d});
		ext_rdata <= 8'($urandom);
		i_btc_host_model.rd(8'h20, 1'b1, r, o);
		check({o, r}, {1'b0, ext_rdata});
		i_btc_host_model.wr(8'h0b, 8'h02);
		n = n_wr;
		i_btc_host_model.wr(8'h90, d);
		check(n_wr, n);
		i_btc_host_model.rd(8'h90, 1'b1, r, o);
		check({o, r}, {1'b1, 8'h00});
		i_btc_host_model.rd(8'h0b, 1'b1, r, o);
		check(o, 1'b1);
		i_btc_host_model.wr(8'h0b, 8'h0a);
		i_btc_host_model.idle(1'b1, 5);
		check(oe_n, 1'b0);
		i_btc_host_model.idle(1'b0, 5);
		check(oe_n, 1'b1);
		i_btc_host_model.wr(8'h0b, 8'h10);
		check({ftp, btm, tso}, 3'h7);
		i_btc_host_model.idle(1'b1, 5);
		check({ftp, btm}, 2'h0);
		n = n_wr;
		i_btc_host_model.rd(8'h0b, 1'b0, r, o);
		check(o, 1'b1);
		check(n_wr, n);
		i_btc_host_model.wr(8'h0b, 8'h05);
		check({hiz, btm}, 2'h3);
		rst_n <= 1'b0;
		@(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		check({hiz, btm}, 2'h0);
		tally_and_finish();
	end
endmodule : btc_board_test_control_test
bind btc_board_test_control btc_board_test_control_sva i_sva (.core_clk(core_clk), .rst_n(rst_n),
	.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
	.data_pin_oe_n(data_pin_oe_n), .ext_wr(ext_wr), .output_pins_hiz(output_pins_hiz),
	.blocks_test_mode(blocks_test_mode), .factory_test_port(factory_test_port), .test_space_open(test_space_open));
`default_nettype wire
